// ---- verilog/tas_core.v ----
// Functional notes
// - Nibble swap exchanges low and high nibbles; no flags; one cycle.
// - Destination bit 0 writes working register, 1 writes the file register.
// - Access bit 0 uses access bank; 1 uses bank select register.
// - Table pointer is 21 bits, one byte per value, 2 Mbyte range.
// - Pointer bit 0 picks low (0) or high (1) program word byte.
// - Table read mode: keep, post-increment, post-decrement, pre-increment.
// - Table read: two cycles, memory read Q2, latch written Q4, no flags.
// - Table write uses the same four pointer modes as table read.
// - Table write: latch read Q2, target written Q4, no flags.
// - Table write takes two cycles, longer while a long write is busy.
// - Test-and-skip on zero discards the next instruction, runs a no-op.
// - Test-and-skip: one cycle, two if skipping, three over two-word instruction.
// - Literal XOR into working register, updates only N and Z.
// - File XOR to destination, updates only N and Z, one cycle.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tas_map.vh"
module tas_core (
    // Clock, reset, enable
    input wire I_REF_CLK,
    input wire I_RST_N,
    input wire I_CLK_EN,
    // APB slave
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output wire O_PREADY,
    output reg [31:0] O_PRDATA,
    output wire O_PSLVERR,
    // Program memory / holding register
    output wire [20:0] O_PM_ADDR,
    output wire O_PM_RD,
    input wire [15:0] I_PM_RDATA,
    output wire O_PM_WR,
    output reg [7:0] O_PM_WDATA,
    input wire I_PM_BUSY,
    // Status
    output wire O_BUSY,
    output wire O_DISCARD
);
    localparam ST_IDLE = 5'b00001;
    localparam ST_C1 = 5'b00010;
    localparam ST_C2 = 5'b00100;
    localparam ST_C3 = 5'b01000;
    localparam ST_LW = 5'b10000;

    localparam Q1 = 4'b0001;
    localparam Q2 = 4'b0010;
    localparam Q3 = 4'b0100;
    localparam Q4 = 4'b1000;

    localparam OP_NOP = 7'b0000001;
    localparam OP_SWAP = 7'b0000010;
    localparam OP_TSTZ = 7'b0000100;
    localparam OP_XORL = 7'b0001000;
    localparam OP_XORF = 7'b0010000;
    localparam OP_TRD = 7'b0100000;
    localparam OP_TWT = 7'b1000000;

    reg [4:0] st_r;
    reg [3:0] q_r;
    reg [6:0] op_r;
    reg [15:0] instr_r;
    reg two_r;
    reg [11:0] fa_r;
    reg [7:0] res_r;
    reg zero_r;
    reg skip_r;
    reg [7:0] working_register_r;
    reg [3:0] bank_r;
    reg [20:0] ptr_r;
    reg [7:0] tlat_r;
    reg neg_r;
    reg zf_r;
    reg [11:0] faddr_r;
    reg [7:0] cyc_r;

    wire [7:0] mem_rdata;
    wire idle = (st_r == ST_IDLE);
    wire [1:0] mode = instr_r[1:0];
    wire dest_f = instr_r[`TAS_DEST_BIT];

    // APB decode
    // Read data loads once per transfer; a setup edge lost to a low enable
    // is made up at the first enabled access edge, at the cost of one wait
    // Writes wait only while the clock enable is low: they take effect at the enabled access edge
    reg rd_vld_r;
    wire rd_load = I_CLK_EN && I_PSEL && !rd_vld_r;
    wire apb_done = I_PSEL && I_PENABLE && I_CLK_EN;
    wire apb_wr = apb_done && I_PWRITE;
    wire addr_ok = (I_PADDR[1:0] == 2'b00) && (I_PADDR <= `TAS_OFS_FDATA);
    wire ro_hit = (I_PADDR == `TAS_OFS_STATUS);
    // All registers refuse writes while an instruction runs
    wire wr_ok = addr_ok && !ro_hit && idle;

    assign O_PREADY = I_CLK_EN && (I_PWRITE || rd_vld_r);
    assign O_PSLVERR = I_PSEL && I_PENABLE && (!addr_ok || (I_PWRITE && !wr_ok));

    function [6:0] op_decode;
        input [15:0] ins;
        begin
            if (ins[15:10] == `TAS_PAT_SWAP) begin
                op_decode = OP_SWAP;
            end else if (ins[15:9] == `TAS_PAT_TSTZ) begin
                op_decode = OP_TSTZ;
            end else if (ins[15:8] == `TAS_PAT_XORL) begin
                op_decode = OP_XORL;
            end else if (ins[15:10] == `TAS_PAT_XORF) begin
                op_decode = OP_XORF;
            end else if (ins[15:2] == `TAS_PAT_TABLE_READ_OP) begin
                op_decode = OP_TRD;
            end else if (ins[15:2] == `TAS_PAT_TABLE_WRITE_OP) begin
                op_decode = OP_TWT;
            end else begin
                op_decode = OP_NOP;
            end
        end
    endfunction

    // Access bank: low half from bank 0, high half from the top bank
    function [11:0] file_addr;
        input [7:0] f;
        input acc;
        input [3:0] bank;
        begin
            if (acc) begin
                file_addr = {bank, f};
            end else if (f < `TAS_ACC_SPLIT) begin
                file_addr = {4'h0, f};
            end else begin
                file_addr = {`TAS_ACC_HI_BANK, f};
            end
        end
    endfunction

    function [20:0] ptr_step;
        input [20:0] p;
        input up;
        begin
            if (up) begin
                ptr_step = p + 21'h000001;
            end else begin
                ptr_step = p - 21'h000001;
            end
        end
    endfunction

    // File memory port: core owns it while busy, software otherwise
    wire core_fwr = (st_r == ST_C1) && (q_r == Q4) && dest_f && (op_r[1] || op_r[4]);
    wire sw_fwr = apb_wr && wr_ok && (I_PADDR == `TAS_OFS_FDATA);
    wire mem_wr = core_fwr || sw_fwr;
    wire [11:0] mem_addr = idle ? faddr_r : fa_r;
    wire [7:0] mem_wdata = idle ? I_PWDATA[7:0] : res_r;

    tas_fram u_fram (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CLK_EN),
        .i_wr(mem_wr),
        .i_addr(mem_addr),
        .i_wdata(mem_wdata),
        .o_rdata(mem_rdata)
    );

    wire in_c2 = (st_r == ST_C2);
    assign O_PM_ADDR = ptr_r;
    // Read request held Q2..Q4 so slow memory has until the Q4 edge
    assign O_PM_RD = in_c2 && op_r[5] && (q_r != Q1);
    assign O_PM_WR = in_c2 && op_r[6] && (q_r == Q4);
    assign O_BUSY = !idle;
    assign O_DISCARD = skip_r && (in_c2 || st_r == ST_C3);

    wire [7:0] pm_byte = ptr_r[0] ? I_PM_RDATA[15:8] : I_PM_RDATA[7:0];
    wire post_mod = (mode == `TAS_MODE_POSTINC) || (mode == `TAS_MODE_POSTDEC);

    always @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_r <= ST_IDLE;
            q_r <= Q1;
            op_r <= OP_NOP;
            instr_r <= 16'h0000;
            two_r <= 1'b0;
            fa_r <= 12'h000;
            res_r <= `TAS_RST_BYTE;
            zero_r <= 1'b0;
            skip_r <= 1'b0;
            working_register_r <= `TAS_RST_BYTE;
            bank_r <= 4'h0;
            ptr_r <= `TAS_RST_PTR;
            tlat_r <= `TAS_RST_BYTE;
            neg_r <= 1'b0;
            zf_r <= 1'b0;
            faddr_r <= 12'h000;
            cyc_r <= 8'h00;
            O_PM_WDATA <= `TAS_RST_BYTE;
        end else if (I_CLK_EN) begin
            if (idle) begin
                q_r <= Q1;
                if (apb_wr && wr_ok) begin
                    case (I_PADDR)
                        `TAS_OFS_INSTR: begin
                            instr_r <= I_PWDATA[15:0];
                            two_r <= I_PWDATA[`TAS_TWO_WORD_BIT];
                            skip_r <= 1'b0;
                            cyc_r <= 8'h00;
                            st_r <= ST_C1;
                        end
                        `TAS_OFS_WORKING_REGISTER: working_register_r <= I_PWDATA[7:0];
                        `TAS_OFS_BANK: bank_r <= I_PWDATA[3:0];
                        `TAS_OFS_TPTR: ptr_r <= I_PWDATA[20:0];
                        `TAS_OFS_TLAT: tlat_r <= I_PWDATA[7:0];
                        `TAS_OFS_FADDR: faddr_r <= I_PWDATA[11:0];
                        default: ;
                    endcase
                end
            end else begin
                q_r <= {q_r[2:0], q_r[3]};
                if (q_r == Q4 && cyc_r != 8'hFF) begin
                    cyc_r <= cyc_r + 8'h01;
                end
                case (st_r)
                    ST_C1: begin
                        case (q_r)
                            Q1: begin
                                op_r <= op_decode(instr_r);
                                fa_r <= file_addr(instr_r[7:0], instr_r[`TAS_ACC_BIT],
                                    bank_r);
                            end
                            Q3: begin
                                // Memory output now holds the Q2 operand read
                                zero_r <= (mem_rdata == 8'h00);
                                if (op_r[1]) begin
                                    res_r <= {mem_rdata[3:0], mem_rdata[7:4]};
                                end else if (op_r[3]) begin
                                    res_r <= working_register_r ^ instr_r[7:0];
                                end else begin
                                    res_r <= working_register_r ^ mem_rdata;
                                end
                            end
                            Q4: begin
                                if ((op_r[1] || op_r[4]) && !dest_f) begin
                                    working_register_r <= res_r;
                                end
                                if (op_r[3]) begin
                                    working_register_r <= res_r;
                                end
                                if (op_r[3] || op_r[4]) begin
                                    neg_r <= res_r[7];
                                    zf_r <= (res_r == 8'h00);
                                end
                                if ((op_r[5] || op_r[6]) && mode == `TAS_MODE_PREINC) begin
                                    ptr_r <= ptr_step(ptr_r, 1'b1);
                                end
                                if (op_r[5] || op_r[6]) begin
                                    st_r <= ST_C2;
                                end else if (op_r[2] && zero_r) begin
                                    skip_r <= 1'b1;
                                    st_r <= ST_C2;
                                end else begin
                                    st_r <= ST_IDLE;
                                end
                            end
                            default: ;
                        endcase
                    end
                    ST_C2: begin
                        if (q_r == Q2 && op_r[6]) begin
                            O_PM_WDATA <= tlat_r;
                        end
                        if (q_r == Q4) begin
                            if (op_r[5]) begin
                                tlat_r <= pm_byte;
                                if (post_mod) begin
                                    ptr_r <= ptr_step(ptr_r, mode[0]);
                                end
                                st_r <= ST_IDLE;
                            end else if (op_r[6]) begin
                                if (I_PM_BUSY) begin
                                    st_r <= ST_LW;
                                end else begin
                                    if (post_mod) begin
                                        ptr_r <= ptr_step(ptr_r, mode[0]);
                                    end
                                    st_r <= ST_IDLE;
                                end
                            end else if (two_r) begin
                                st_r <= ST_C3;
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_C3: begin
                        if (q_r == Q4) begin
                            st_r <= ST_IDLE;
                        end
                    end
                    ST_LW: begin
                        // Finish only on an instruction-cycle boundary
                        if (q_r == Q4 && !I_PM_BUSY) begin
                            if (post_mod) begin
                                ptr_r <= ptr_step(ptr_r, mode[0]);
                            end
                            st_r <= ST_IDLE;
                        end
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end
        end
    end

    // Completing edge clears it so a back-to-back setup reloads
    always @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rd_vld_r <= 1'b0;
        end else if (I_CLK_EN) begin
            rd_vld_r <= I_PSEL && !(I_PENABLE && O_PREADY);
        end
    end

    // File data valid only when idle, and one idle cycle after an address write
    always @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_PRDATA <= 32'h00000000;
        end else if (rd_load) begin
            case (I_PADDR)
                `TAS_OFS_INSTR: O_PRDATA <= {15'h0000, two_r, instr_r};
                `TAS_OFS_STATUS: O_PRDATA <= {16'h0000, cyc_r, 4'h0, skip_r, zf_r,
                    neg_r, !idle};
                `TAS_OFS_WORKING_REGISTER: O_PRDATA <= {24'h000000, working_register_r};
                `TAS_OFS_BANK: O_PRDATA <= {28'h0000000, bank_r};
                `TAS_OFS_TPTR: O_PRDATA <= {11'h000, ptr_r};
                `TAS_OFS_TLAT: O_PRDATA <= {24'h000000, tlat_r};
                `TAS_OFS_FADDR: O_PRDATA <= {20'h00000, faddr_r};
                `TAS_OFS_FDATA: O_PRDATA <= {24'h000000, mem_rdata};
                default: O_PRDATA <= 32'h00000000;
            endcase
        end
    end
endmodule

// ---- verilog/tas_map.vh ----
`ifndef TAS_MAP_VH
`define TAS_MAP_VH

// Register offsets (byte addresses)
`define TAS_OFS_INSTR 8'h00
`define TAS_OFS_STATUS 8'h04
`define TAS_OFS_WORKING_REGISTER 8'h08
`define TAS_OFS_BANK 8'h0C
`define TAS_OFS_TPTR 8'h10
`define TAS_OFS_TLAT 8'h14
`define TAS_OFS_FADDR 8'h18
`define TAS_OFS_FDATA 8'h1C

// Instruction register fields
`define TAS_INSTR_W 16
`define TAS_TWO_WORD_BIT 16
`define TAS_DEST_BIT 9
`define TAS_ACC_BIT 8

// Status register fields
`define TAS_ST_BUSY_BIT 0
`define TAS_ST_NEG_BIT 1
`define TAS_ST_ZERO_BIT 2
`define TAS_ST_SKIP_BIT 3
`define TAS_ST_CYC_LSB 8

// Opcode patterns
`define TAS_PAT_SWAP 6'h0E
`define TAS_PAT_TSTZ 7'h33
`define TAS_PAT_XORL 8'h0A
`define TAS_PAT_XORF 6'h06
`define TAS_PAT_TABLE_READ_OP 14'h0002
`define TAS_PAT_TABLE_WRITE_OP 14'h0003

// Table pointer modes
`define TAS_MODE_KEEP 2'h0
`define TAS_MODE_POSTINC 2'h1
`define TAS_MODE_POSTDEC 2'h2
`define TAS_MODE_PREINC 2'h3

// Widths and reset values
`define TAS_PTR_W 21
`define TAS_FA_W 12
`define TAS_ACC_SPLIT 8'h80
`define TAS_ACC_HI_BANK 4'hF
`define TAS_RST_BYTE 8'h00
`define TAS_RST_PTR 21'h000000

`endif

// ---- verilog/tas_fram.v ----
`timescale 1ns/1ps
module tas_fram (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ce,
    // Access port
    input wire i_wr,
    input wire [11:0] i_addr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata
);
    reg [7:0] mem [0:4095];

    // Read-first: a write shows up on the next read cycle
    always @(posedge i_clk) begin
        if (i_ce && i_wr) begin
            mem[i_addr] <= i_wdata;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule

// ---- sim/tas_core_assertions.sv ----
`timescale 1ns/1ps
module tas_core_assertions (
    // Watched ports
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    input wire logic O_PM_RD,
    input wire logic O_PM_WR,
    input wire logic [7:0] O_PM_WDATA,
    input wire logic [20:0] O_PM_ADDR,
    input wire logic I_PM_BUSY,
    input wire logic O_BUSY,
    input wire logic O_DISCARD
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RST_N);
    AST_RD_THREE: assert property ($rose(O_PM_RD) |-> O_PM_RD[*3] ##1 !O_PM_RD)
        else $error("read strobe length wrong");
    AST_RD_END: assert property ($fell(O_PM_RD) |-> $fell(O_BUSY))
        else $error("table read did not end with strobe");
    AST_WR_PULSE: assert property (O_PM_WR |=> !O_PM_WR)
        else $error("write strobe longer than one clock");
    AST_WR_DATA: assert property (O_PM_WR |-> $stable(O_PM_WDATA) && O_BUSY)
        else $error("write data moved under strobe");
    AST_WR_DONE: assert property (O_PM_WR && !I_PM_BUSY |=> !O_BUSY)
        else $error("short table write overran");
    AST_LONG_HOLD: assert property (O_PM_WR && I_PM_BUSY |=> O_BUSY[*4])
        else $error("long write ended early");
    AST_ADDR_HOLD: assert property (O_PM_RD && $past(O_PM_RD) |-> $stable(O_PM_ADDR))
        else $error("pointer moved during read");
    AST_EXCL: assert property (!(O_PM_RD && O_PM_WR))
        else $error("read and write at once");
    AST_DISC_QUIET: assert property (O_DISCARD |-> O_BUSY && !O_PM_RD && !O_PM_WR)
        else $error("discard cycle not a no-op");
    AST_DISC_LEN: assert property ($rose(O_DISCARD) |-> O_DISCARD[*4])
        else $error("discard shorter than one cycle");
    cover property ($rose(O_PM_RD));
    cover property (O_PM_WR && I_PM_BUSY);
    cover property ($rose(O_DISCARD));
endmodule
bind tas_core tas_core_assertions tas_core_assertions_i (
    .I_REF_CLK(I_REF_CLK),
    .I_RST_N(I_RST_N),
    .O_PM_RD(O_PM_RD),
    .O_PM_WR(O_PM_WR),
    .O_PM_WDATA(O_PM_WDATA),
    .O_PM_ADDR(O_PM_ADDR),
    .I_PM_BUSY(I_PM_BUSY),
    .O_BUSY(O_BUSY),
    .O_DISCARD(O_DISCARD)
);

// ---- sim/tas_pm_model.sv ----
`timescale 1ns/1ps
module tas_pm_model #(parameter int LONG_CNT = 10) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Memory port
    input wire logic [20:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_long,
    output logic [15:0] o_rdata,
    output logic o_busy
);
    // Only 256 words decoded; upper pointer bits alias
    logic [15:0] mem [0:255];
    logic [15:0] idle_r;
    int cnt_r;
    initial for (int i = 0; i < 256; i++) mem[i] = {~8'(i), 8'(i)};
    // Toggles when not read so stale data never matches
    assign o_rdata = i_rd ? mem[i_addr[8:1]] : idle_r;
    assign o_busy = (i_wr && i_long) || cnt_r != 0;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_r <= 16'h5AA5;
            cnt_r <= 0;
        end else begin
            idle_r <= ~idle_r;
            if (i_wr) begin
                if (i_addr[0]) mem[i_addr[8:1]][15:8] <= i_wdata;
                else mem[i_addr[8:1]][7:0] <= i_wdata;
                cnt_r <= i_long ? LONG_CNT : 0;
            end else if (cnt_r != 0) begin
                cnt_r <= cnt_r - 1;
            end
        end
    end
endmodule

// ---- sim/table_access_and_alu_ops_test.sv ----
`timescale 1ns/1ps
`include "tas_map.vh"
module table_access_and_alu_ops_test;
    typedef struct packed {
        logic [16:0] ins;
        logic [11:0] fa;
        logic [7:0] fv, w, ew, ef;
        logic [15:0] st;
    } tas_row_t;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, long_wr = 0, ce = 1, er;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [20:0] p, q;
    logic [7:0] b;
    wire pready, perr, pm_rd, pm_wr, pm_busy, busy, disc;
    wire [20:0] pm_addr;
    wire [15:0] pm_rdata;
    wire [7:0] pm_wdata;
    int error_cnt = 0, samples_checked = 0;
    tas_row_t rows [10] = '{
        '{17'h00A5A, 12'h000, 8'h00, 8'h5A, 8'h00, 8'h00, 16'h0104},
        '{17'h03A10, 12'h010, 8'h53, 8'h11, 8'h11, 8'h35, 16'h0104},
        '{17'h03920, 12'h220, 8'h53, 8'h11, 8'h35, 8'h53, 16'h0104},
        '{17'h00AAF, 12'h000, 8'h00, 8'hB5, 8'h1A, 8'h00, 16'h0100},
        '{17'h01A20, 12'h020, 8'hAF, 8'hB5, 8'hB5, 8'h1A, 16'h0100},
        '{17'h01830, 12'h030, 8'h80, 8'h01, 8'h81, 8'h80, 16'h0102},
        '{17'h01890, 12'hF90, 8'h0F, 8'hF0, 8'hFF, 8'h0F, 16'h0102},
        '{17'h06640, 12'h040, 8'h07, 8'h33, 8'h33, 8'h07, 16'h0102},
        '{17'h06744, 12'h244, 8'h00, 8'h33, 8'h33, 8'h00, 16'h020A},
        '{17'h16640, 12'h040, 8'h00, 8'h33, 8'h33, 8'h00, 16'h030A}};
    always #50 clk = ~clk;
    tas_core tas_core_i (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_CLK_EN(ce),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(perr),
        .O_PM_ADDR(pm_addr), .O_PM_RD(pm_rd), .I_PM_RDATA(pm_rdata), .O_PM_WR(pm_wr),
        .O_PM_WDATA(pm_wdata), .I_PM_BUSY(pm_busy), .O_BUSY(busy), .O_DISCARD(disc));
    tas_pm_model tas_pm_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_addr(pm_addr),
        .i_rd(pm_rd), .i_wr(pm_wr), .i_wdata(pm_wdata), .i_long(long_wr),
        .o_rdata(pm_rdata), .o_busy(pm_busy));
    task stop_test;
        $display("Counts: %0d mismatches, %0d checks", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask
    task run(input logic [16:0] ins);
        apb(1, `TAS_OFS_INSTR, 32'(ins));
        do apb(0, `TAS_OFS_STATUS, 0); while (rd[0] !== 1'b0);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        rdc(`TAS_OFS_STATUS, 0);
        rdc(`TAS_OFS_TPTR, 0);
        rdc(`TAS_OFS_WORKING_REGISTER, 0);
        apb(1, `TAS_OFS_TPTR, 32'hFFFFFFFF);
        rdc(`TAS_OFS_TPTR, 32'h001FFFFF);
        apb(0, 8'h20, 0);
        chk(32'(er), 1);
        $display("Reset and map test done");
        apb(1, `TAS_OFS_BANK, 2);
        foreach (rows[i]) begin
            apb(1, `TAS_OFS_FADDR, 32'(rows[i].fa));
            apb(1, `TAS_OFS_FDATA, 32'(rows[i].fv));
            apb(1, `TAS_OFS_WORKING_REGISTER, 32'(rows[i].w));
            run(rows[i].ins);
            rdc(`TAS_OFS_WORKING_REGISTER, 32'(rows[i].ew));
            rdc(`TAS_OFS_FDATA, 32'(rows[i].ef));
            rdc(`TAS_OFS_STATUS, 32'(rows[i].st));
            $display("Row %0d done", i);
        end
        for (int m = 0; m < 4; m++) begin
            p = 21'h1A357;
            apb(1, `TAS_OFS_TPTR, 32'(p));
            run(17'h00008 | 17'(m));
            q = (m == 3) ? p + 1 : p;
            b = q[0] ? ~q[8:1] : q[8:1];
            rdc(`TAS_OFS_TLAT, 32'(b));
            rdc(`TAS_OFS_TPTR, 32'(m == 1 ? q + 1 : m == 2 ? q - 1 : q));
            apb(0, `TAS_OFS_STATUS, 0);
            chk(32'({rd[15:8], rd[2:1]}), {22'h0, 8'h02, 2'b01});
            p = 21'h1389A;
            apb(1, `TAS_OFS_TPTR, 32'(p));
            apb(1, `TAS_OFS_TLAT, 32'h30 + m);
            run(17'h0000C | 17'(m));
            q = (m == 3) ? p + 1 : p;
            b = q[0] ? tas_pm_model_i.mem[q[8:1]][15:8] : tas_pm_model_i.mem[q[8:1]][7:0];
            chk(32'(b), 32'h30 + m);
            rdc(`TAS_OFS_TPTR, 32'(m == 1 ? q + 1 : m == 2 ? q - 1 : q));
            apb(0, `TAS_OFS_STATUS, 0);
            chk(32'({rd[15:8], rd[2:1]}), {22'h0, 8'h02, 2'b01});
            $display("Table mode %0d done", m);
        end
        long_wr <= 1;
        apb(1, `TAS_OFS_TLAT, 32'h77);
        apb(1, `TAS_OFS_WORKING_REGISTER, 32'h5C);
        apb(1, `TAS_OFS_INSTR, 32'h0000C);
        apb(1, `TAS_OFS_WORKING_REGISTER, 32'hEE);
        chk(32'(er), 1);
        do apb(0, `TAS_OFS_STATUS, 0); while (rd[0] !== 1'b0);
        chk(32'(rd[15:8]), 32'h05);
        rdc(`TAS_OFS_WORKING_REGISTER, 32'h5C);
        chk(32'(tas_pm_model_i.mem[q[8:1]][15:8]), 32'h77);
        long_wr <= 0;
        $display("Long write test done");
        apb(1, `TAS_OFS_WORKING_REGISTER, 32'h3C);
        apb(1, `TAS_OFS_INSTR, 32'h00A0F);
        ce <= 0;
        repeat (10) @(posedge clk);
        chk(32'({busy, pready}), 32'h2);
        fork
            rdc(`TAS_OFS_WORKING_REGISTER, 32'h3C);
            begin
                repeat (3) @(posedge clk);
                ce <= 1;
            end
        join
        do apb(0, `TAS_OFS_STATUS, 0); while (rd[0] !== 1'b0);
        rdc(`TAS_OFS_WORKING_REGISTER, 32'h33);
        rdc(`TAS_OFS_STATUS, 32'h0100);
        $display("Clock enable test done");
        apb(1, `TAS_OFS_TPTR, 32'h00155);
        apb(1, `TAS_OFS_INSTR, 32'h00009);
        repeat (6) @(posedge clk);
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        chk(32'({busy, pm_rd}), 0);
        rdc(`TAS_OFS_TPTR, 0);
        rdc(`TAS_OFS_STATUS, 0);
        $display("Mid-run reset test done");
        stop_test;
    end
endmodule
